// >>> src/qrs_pkg.sv
// Shared constants and types for the burst SRAM pin interface pair
package qrs_pkg;

   // Pin widths
   localparam int ADDR_W      = 18;
   localparam int DATA_W      = 36;
   localparam int BYTE_W      = 9;
   localparam int BW_N        = 4;
   localparam int NARROW_BYTES = 2;

   // Burst shape: four words over two link cycles
   localparam int BURST       = 4;
   localparam int WSEL_W      = 2;
   localparam logic [WSEL_W-1:0] WORD0 = 2'h0;
   localparam logic [WSEL_W-1:0] WORD1 = 2'h1;
   localparam logic [WSEL_W-1:0] WORD2 = 2'h2;
   localparam logic [WSEL_W-1:0] WORD3 = 2'h3;

   // Stored bursts (flip-flop array, indexed by low address bits)
   localparam int MEM_IDX_W   = 4;
   localparam int MEM_WORDS   = (1 << MEM_IDX_W) * BURST;

   // Bypass-mode frequency ceiling, informational
   localparam int DLL_OFF_MAX_MHZ = 167;

   // Host link clock: sys_clk cycles per half link period
   localparam int PH_W        = 2;
   localparam logic [PH_W-1:0] K_HALF       = 2'h2;
   localparam logic [PH_W-1:0] PH_LAST      = 2'h3;
   localparam logic [PH_W-1:0] PH_FALL_PREP = 2'h1;
   localparam logic [PH_W-1:0] PH_RISE_PREP = 2'h3;
   localparam logic [2:0]      CNT_DONE     = 3'h4;

   typedef logic [DATA_W-1:0] qrs_word_t;

   // Host sequencer states
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_CMD   = 2'b01,
      H_WDATA = 2'b10,
      H_RWAIT = 2'b11
   } qrs_hstate_t;

endpackage

// >>> src/qrs_if.sv
// Pin bundle between host controller and burst SRAM device
`timescale 1ns/100ps
interface qrs_if;
   import qrs_pkg::*;

   logic              k;         // Input clock, true
   logic              k_n;       // Input clock, complement
   logic [ADDR_W-1:0] addr_in;
   logic              rd_sel_n;
   logic              wr_sel_n;
   logic [DATA_W-1:0] write_data_in;
   logic [BW_N-1:0]   byte_write_enable_n;
   logic              dll_off_n;
   logic [DATA_W-1:0] read_data_out;
   logic              read_oe_n;  // Low while device drives read data
   logic              echo_clk;
   logic              echo_clk_n;
   logic              output_valid_indicator;

   modport host (
      output k, k_n, addr_in, rd_sel_n, wr_sel_n, write_data_in,
      output byte_write_enable_n, dll_off_n,
      input  read_data_out, read_oe_n, echo_clk, echo_clk_n,
      input  output_valid_indicator
   );

   modport dev (
      input  k, k_n, addr_in, rd_sel_n, wr_sel_n, write_data_in,
      input  byte_write_enable_n, dll_off_n,
      output read_data_out, read_oe_n, echo_clk, echo_clk_n,
      output output_valid_indicator
   );

endinterface

// >>> src/qrs_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
module qrs_sync2 (
   // Destination clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Level in and synchronised level out
   input  wire logic d,
   output logic      q
);

   logic meta_ff;
   logic q_ff;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         q_ff    <= 1'b0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule // qrs_sync2

// >>> src/qrs_sram_dev.sv
// Device end: burst SRAM pin logic clocked by the link clock
//
// Notes on behaviour
// - Valid indicator marks read words, echo-aligned
// - Address taken on K rise, ignored deselected
// - Write data sampled on K and K# rises
// - 18-bit build uses lower data bits only
// - Read bus driven only for read bursts
// - Low write select starts write, captures address
// - Low read select starts read, captures address
// - Byte enables sampled with data, low writes
// - Echo clocks run freely, even when idle
// - DLL off selects one-cycle read latency
`timescale 1ns/100ps
module qrs_sram_dev
   import qrs_pkg::*;
#(
   parameter bit WIDE36 = 1'b1
) (
   // Link pins
   qrs_if.dev        lnk,
   // User side
   input  wire logic sys_clk,
   input  wire logic reset_n,
   output logic      busy_sys
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   qrs_word_t             mem_ff [MEM_WORDS];
   qrs_word_t             nxt_mem [MEM_WORDS];
   logic [3:1]            wv_ff, nxt_wv;
   logic [MEM_IDX_W-1:0]  wa_ff [1:3];
   logic [MEM_IDX_W-1:0]  nxt_wa [1:3];
   logic [4:1]            rv_ff, nxt_rv;
   logic [MEM_IDX_W-1:0]  ra_ff [1:4];
   logic [MEM_IDX_W-1:0]  nxt_ra [1:4];
   qrs_word_t             q_k_ff, nxt_q_k;
   logic                  qv_k_ff, nxt_qv_k;
   logic                  busy_k_ff, nxt_busy_k;
   qrs_word_t             dkn_ff, nxt_dkn;
   logic [BW_N-1:0]       bkn_ff, nxt_bkn;
   qrs_word_t             q_kn_ff, nxt_q_kn;
   logic                  qv_kn_ff, nxt_qv_kn;
   logic                  dll_byp_k;
   logic                  wr_go;
   logic                  rd_go;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Flat word index from burst index and word number
   function automatic int widx(input logic [MEM_IDX_W-1:0] idx,
                               input logic [WSEL_W-1:0] w);
      widx = int'({idx, w});
   endfunction

   // Merge new bytes whose enables are low; narrow build skips top bytes
   function automatic qrs_word_t merge(input qrs_word_t old_w,
                                       input qrs_word_t new_w,
                                       input logic [BW_N-1:0] be_n);
      qrs_word_t r;
      r = old_w;
      for (int b = 0; b < BW_N; b++) begin
         if (!be_n[b] && (WIDE36 || b < NARROW_BYTES)) begin
            r[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
         end
      end
      merge = r;
   endfunction

   // Bus side mask so unused upper pins of a narrow build stay low
   function automatic qrs_word_t lane_mask(input qrs_word_t w);
      qrs_word_t r;
      r = w;
      if (!WIDE36) begin
         r[DATA_W-1:NARROW_BYTES*BYTE_W] = '0;
      end
      lane_mask = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bypass control crosses into the link domain, inverted so that the
   // cleared synchroniser means DLL on, matching the pin's idle level

   qrs_sync2 u_dll_sync (
      .clk     (lnk.k),
      .reset_n (reset_n),
      .d       (!lnk.dll_off_n),
      .q       (dll_byp_k)
   );

   // Busy level crosses back to the user clock
   qrs_sync2 u_busy_sync (
      .clk     (sys_clk),
      .reset_n (reset_n),
      .d       (busy_k_ff),
      .q       (busy_sys)
   );

   ////////////////////////////////////////////////////////////////////////
   // K rising edge: commands, write commit, even-half read words

   // A select low starts a burst; a select of the same kind on the very next
   // edge is ignored because the previous burst still owns that data bus
   assign wr_go = !lnk.wr_sel_n && !wv_ff[1];
   assign rd_go = !lnk.rd_sel_n && !rv_ff[1];

   // Next state for the K-rise group
   always_comb begin
      nxt_mem = mem_ff;
      nxt_wv  = {wv_ff[2:1], wr_go};
      nxt_rv  = {rv_ff[3:1], rd_go};
      nxt_wa  = wa_ff;
      nxt_ra  = ra_ff;
      // Address only captured when selected
      if (wr_go) begin
         nxt_wa[1] = lnk.addr_in[MEM_IDX_W-1:0];
      end
      if (rd_go) begin
         nxt_ra[1] = lnk.addr_in[MEM_IDX_W-1:0];
      end
      nxt_wa[2] = wa_ff[1];
      nxt_wa[3] = wa_ff[2];
      nxt_ra[2] = ra_ff[1];
      nxt_ra[3] = ra_ff[2];
      nxt_ra[4] = ra_ff[3];
      // Words 0 and 2 come on K rise, 1 and 3 from the K# capture
      if (wv_ff[1]) begin
         nxt_mem[widx(wa_ff[1], WORD0)] =
            merge(mem_ff[widx(wa_ff[1], WORD0)], lnk.write_data_in,
                  lnk.byte_write_enable_n);
      end
      if (wv_ff[2]) begin
         nxt_mem[widx(wa_ff[2], WORD1)] =
            merge(mem_ff[widx(wa_ff[2], WORD1)], dkn_ff, bkn_ff);
         nxt_mem[widx(wa_ff[2], WORD2)] =
            merge(mem_ff[widx(wa_ff[2], WORD2)], lnk.write_data_in,
                  lnk.byte_write_enable_n);
      end
      if (wv_ff[3]) begin
         nxt_mem[widx(wa_ff[3], WORD3)] =
            merge(mem_ff[widx(wa_ff[3], WORD3)], dkn_ff, bkn_ff);
      end
      // Read words launched on K rise
      nxt_q_k  = '0;
      nxt_qv_k = 1'b0;
      if (dll_byp_k) begin
         // Bypass: first word one cycle after the command
         if (rv_ff[1]) begin
            nxt_q_k  = mem_ff[widx(ra_ff[1], WORD0)];
            nxt_qv_k = 1'b1;
         end else if (rv_ff[2]) begin
            nxt_q_k  = mem_ff[widx(ra_ff[2], WORD2)];
            nxt_qv_k = 1'b1;
         end
      end else begin
         if (rv_ff[3]) begin
            nxt_q_k  = mem_ff[widx(ra_ff[3], WORD1)];
            nxt_qv_k = 1'b1;
         end else if (rv_ff[4]) begin
            nxt_q_k  = mem_ff[widx(ra_ff[4], WORD3)];
            nxt_qv_k = 1'b1;
         end
      end
      nxt_busy_k = |{nxt_wv, nxt_rv};
   end

   // Registers of the K-rise group
   always_ff @(posedge lnk.k or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_ff[i] <= '0;
         end
         wv_ff     <= '0;
         rv_ff     <= '0;
         for (int i = 1; i <= 3; i++) begin
            wa_ff[i] <= '0;
         end
         for (int i = 1; i <= 4; i++) begin
            ra_ff[i] <= '0;
         end
         q_k_ff    <= '0;
         qv_k_ff   <= 1'b0;
         busy_k_ff <= 1'b0;
      end else begin
         mem_ff    <= nxt_mem;
         wv_ff     <= nxt_wv;
         rv_ff     <= nxt_rv;
         wa_ff     <= nxt_wa;
         ra_ff     <= nxt_ra;
         q_k_ff    <= nxt_q_k;
         qv_k_ff   <= nxt_qv_k;
         busy_k_ff <= nxt_busy_k;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // K# rising edge: odd write words, odd-half read words

   // Next state for the K#-rise group
   always_comb begin
      nxt_dkn   = lnk.write_data_in;
      nxt_bkn   = lnk.byte_write_enable_n;
      nxt_q_kn  = '0;
      nxt_qv_kn = 1'b0;
      if (dll_byp_k) begin
         if (rv_ff[2]) begin
            nxt_q_kn  = mem_ff[widx(ra_ff[2], WORD1)];
            nxt_qv_kn = 1'b1;
         end else if (rv_ff[3]) begin
            nxt_q_kn  = mem_ff[widx(ra_ff[3], WORD3)];
            nxt_qv_kn = 1'b1;
         end
      end else begin
         // Two and a half cycles after the command
         if (rv_ff[3]) begin
            nxt_q_kn  = mem_ff[widx(ra_ff[3], WORD0)];
            nxt_qv_kn = 1'b1;
         end else if (rv_ff[4]) begin
            nxt_q_kn  = mem_ff[widx(ra_ff[4], WORD2)];
            nxt_qv_kn = 1'b1;
         end
      end
   end

   // Registers of the K#-rise group
   always_ff @(posedge lnk.k_n or negedge reset_n) begin
      if (!reset_n) begin
         dkn_ff   <= '0;
         bkn_ff   <= '1;
         q_kn_ff  <= '0;
         qv_kn_ff <= 1'b0;
      end else begin
         dkn_ff   <= nxt_dkn;
         bkn_ff   <= nxt_bkn;
         q_kn_ff  <= nxt_q_kn;
         qv_kn_ff <= nxt_qv_kn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pins

   // Each half of K shows the word launched on its opening edge, so
   // data and valid change exactly with the echo clock edges
   assign lnk.read_data_out = lane_mask(lnk.k ? q_k_ff : q_kn_ff);
   assign lnk.output_valid_indicator =
      lnk.k ? qv_k_ff : qv_kn_ff;
   assign lnk.read_oe_n = lnk.k ? !qv_k_ff : !qv_kn_ff;

   // Echo clocks follow the input clock pair at all times
   assign lnk.echo_clk   = lnk.k;
   assign lnk.echo_clk_n = lnk.k_n;

endmodule // qrs_sram_dev

// >>> src/qrs_sram_host.sv
// Host end: memory controller that makes the link clock and runs bursts
`timescale 1ns/100ps
module qrs_sram_host
   import qrs_pkg::*;
(
   // Link pins
   qrs_if.host                           lnk,
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   // Request side
   input  wire logic                     user_wr_req,
   input  wire logic                     user_rd_req,
   input  wire logic [ADDR_W-1:0]        user_addr,
   input  wire logic [BURST*DATA_W-1:0]  user_wdata,
   input  wire logic [BURST*BW_N-1:0]    user_bw_n,
   input  wire logic                     user_dll_off_n,
   output logic                          user_ready,
   // Answer side
   output logic [BURST*DATA_W-1:0]       user_rdata,
   output logic                          user_rvalid
);

   qrs_hstate_t               st_ff, nxt_st;
   logic [PH_W-1:0]           ph_ff, nxt_ph;
   logic                      k_ff, nxt_k;
   logic [ADDR_W-1:0]         addr_ff, nxt_addr;
   logic                      rd_n_ff, nxt_rd_n;
   logic                      wr_n_ff, nxt_wr_n;
   logic [DATA_W-1:0]         d_ff, nxt_d;
   logic [BW_N-1:0]           bw_n_ff, nxt_bw_n;
   logic                      doff_ff, nxt_doff;
   logic                      is_wr_ff, nxt_is_wr;
   logic [2:0]                cnt_ff, nxt_cnt;
   logic [BURST*DATA_W-1:0]   wbuf_ff, nxt_wbuf;
   logic [BURST*BW_N-1:0]     bbuf_ff, nxt_bbuf;
   logic [BURST*DATA_W-1:0]   rdata_ff, nxt_rdata;
   logic                      rvalid_ff, nxt_rvalid;
   logic                      prep;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: pins change mid-half, away from the K edges

   assign prep = (ph_ff == PH_FALL_PREP) || (ph_ff == PH_RISE_PREP);

   // Next state of the whole host
   always_comb begin
      nxt_ph     = (ph_ff == PH_LAST) ? '0 : ph_ff + 1'b1;
      nxt_k      = (ph_ff < K_HALF);  // Lags phase: pins lead each edge
      nxt_st     = st_ff;
      nxt_addr   = addr_ff;
      nxt_rd_n   = rd_n_ff;
      nxt_wr_n   = wr_n_ff;
      nxt_d      = d_ff;
      nxt_bw_n   = bw_n_ff;
      nxt_doff   = user_dll_off_n;
      nxt_is_wr  = is_wr_ff;
      nxt_cnt    = cnt_ff;
      nxt_wbuf   = wbuf_ff;
      nxt_bbuf   = bbuf_ff;
      nxt_rdata  = rdata_ff;
      nxt_rvalid = 1'b0;
      case (st_ff)
         H_IDLE: begin
            if (ph_ff == PH_RISE_PREP && (user_wr_req || user_rd_req)) begin
               nxt_is_wr = user_wr_req;
               nxt_wr_n  = !user_wr_req;
               nxt_rd_n  = user_wr_req;
               nxt_addr  = user_addr;
               nxt_wbuf  = user_wdata;
               nxt_bbuf  = user_bw_n;
               nxt_cnt   = '0;
               nxt_st    = H_CMD;
            end
         end
         H_CMD: begin
            // Select held across exactly one K rise
            if (ph_ff == PH_RISE_PREP) begin
               nxt_wr_n = 1'b1;
               nxt_rd_n = 1'b1;
               nxt_st   = is_wr_ff ? H_WDATA : H_RWAIT;
               if (is_wr_ff) begin
                  nxt_d    = wbuf_ff[0 +: DATA_W];
                  nxt_bw_n = bbuf_ff[0 +: BW_N];
                  nxt_cnt  = 3'h1;
               end
            end
         end
         H_WDATA: begin
            // One word centred on each K and K# rise, four in all
            if (prep) begin
               if (cnt_ff == CNT_DONE) begin
                  nxt_bw_n = '1;
                  nxt_st   = H_IDLE;
               end else begin
                  nxt_d    = wbuf_ff[cnt_ff[1:0]*DATA_W +: DATA_W];
                  nxt_bw_n = bbuf_ff[cnt_ff[1:0]*BW_N +: BW_N];
                  nxt_cnt  = cnt_ff + 1'b1;
               end
            end
         end
         H_RWAIT: begin
            // Collect words marked valid, in order
            if (prep && lnk.output_valid_indicator) begin
               nxt_rdata[cnt_ff[1:0]*DATA_W +: DATA_W] = lnk.read_data_out;
               nxt_cnt = cnt_ff + 1'b1;
               if (cnt_ff == CNT_DONE - 1'b1) begin
                  nxt_rvalid = 1'b1;
                  nxt_st     = H_IDLE;
               end
            end
         end
         default: begin
            nxt_st = H_IDLE;
         end
      endcase
   end

   // Host registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff     <= H_IDLE;
         ph_ff     <= '0;
         k_ff      <= 1'b1;
         addr_ff   <= '0;
         rd_n_ff   <= 1'b1;
         wr_n_ff   <= 1'b1;
         d_ff      <= '0;
         bw_n_ff   <= '1;
         doff_ff   <= 1'b1;
         is_wr_ff  <= 1'b0;
         cnt_ff    <= '0;
         wbuf_ff   <= '0;
         bbuf_ff   <= '1;
         rdata_ff  <= '0;
         rvalid_ff <= 1'b0;
      end else begin
         st_ff     <= nxt_st;
         ph_ff     <= nxt_ph;
         k_ff      <= nxt_k;
         addr_ff   <= nxt_addr;
         rd_n_ff   <= nxt_rd_n;
         wr_n_ff   <= nxt_wr_n;
         d_ff      <= nxt_d;
         bw_n_ff   <= nxt_bw_n;
         doff_ff   <= nxt_doff;
         is_wr_ff  <= nxt_is_wr;
         cnt_ff    <= nxt_cnt;
         wbuf_ff   <= nxt_wbuf;
         bbuf_ff   <= nxt_bbuf;
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins and user outputs

   assign lnk.k                   = k_ff;
   assign lnk.k_n                 = !k_ff;
   assign lnk.addr_in             = addr_ff;
   assign lnk.rd_sel_n            = rd_n_ff;
   assign lnk.wr_sel_n            = wr_n_ff;
   assign lnk.write_data_in       = d_ff;
   assign lnk.byte_write_enable_n = bw_n_ff;
   assign lnk.dll_off_n           = doff_ff;
   assign user_ready              = (st_ff == H_IDLE);
   assign user_rdata              = rdata_ff;
   assign user_rvalid             = rvalid_ff;

endmodule // qrs_sram_host

// >>> tb/qrs_link_props.sv
// Link checker: timing relations on the burst SRAM pins
`timescale 1ns/100ps
module qrs_link_props
   import qrs_pkg::*;
(
   // Clocks and reset
   input wire logic              sys_clk,
   input wire logic              reset_n,
   input wire logic              k,
   input wire logic              k_n,
   // Commands
   input wire logic              rd_sel_n,
   input wire logic              wr_sel_n,
   input wire logic              dll_off_n,
   // Read side
   input wire logic [DATA_W-1:0] read_data_out,
   input wire logic              read_oe_n,
   input wire logic              echo_clk,
   input wire logic              echo_clk_n,
   input wire logic              output_valid_indicator
);

   ////////////////////////////////////////////////////////////////////////
   // Echo clocks: copies of the input pair, never stopping
   property p_echo_copy;
      @(posedge sys_clk) disable iff (!reset_n)
         echo_clk == k && echo_clk_n == k_n;
   endproperty
   a_echo_copy: assert property (p_echo_copy)
      else $error("echo clocks differ from input clocks");

   property p_echo_runs;
      @(posedge sys_clk) disable iff (!reset_n)
         $rose(echo_clk) |-> ##4 $rose(echo_clk);
   endproperty
   a_echo_runs: assert property (p_echo_runs)
      else $error("echo clock period broken");

   ////////////////////////////////////////////////////////////////////////
   // Read bus: driven only with valid words, changing at echo edges
   property p_oe_valid;
      @(posedge sys_clk) disable iff (!reset_n)
         read_oe_n == !output_valid_indicator;
   endproperty
   a_oe_valid: assert property (p_oe_valid)
      else $error("read enable disagrees with valid indicator");

   property p_q_zero;
      @(posedge sys_clk) disable iff (!reset_n)
         !output_valid_indicator |-> read_data_out == '0;
   endproperty
   a_q_zero: assert property (p_q_zero)
      else $error("read bus active without valid word");

   property p_valid_edge;
      @(posedge sys_clk) disable iff (!reset_n)
         ($changed(output_valid_indicator) || $changed(read_oe_n))
         |-> $changed(echo_clk);
   endproperty
   a_valid_edge: assert property (p_valid_edge)
      else $error("valid indicator moved off an echo edge");

   ////////////////////////////////////////////////////////////////////////
   // Read latency in both modes, sampled at input clock rises
   property p_rd_lat_on;
      @(posedge k) disable iff (!reset_n)
         (!rd_sel_n && $past(rd_sel_n) && dll_off_n)
         |-> ##3 output_valid_indicator ##1 output_valid_indicator;
   endproperty
   a_rd_lat_on: assert property (p_rd_lat_on)
      else $error("read words late or missing with DLL on");

   property p_rd_lat_off;
      @(posedge k) disable iff (!reset_n)
         (!rd_sel_n && $past(rd_sel_n) && !dll_off_n)
         |-> ##2 output_valid_indicator ##1 output_valid_indicator;
   endproperty
   a_rd_lat_off: assert property (p_rd_lat_off)
      else $error("read words late or missing with DLL bypassed");

   property p_valid_cause;
      @(posedge k) disable iff (!reset_n)
         output_valid_indicator |-> (!$past(rd_sel_n, 2)
         || !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4));
   endproperty
   a_valid_cause: assert property (p_valid_cause)
      else $error("valid word without a read command");

   ////////////////////////////////////////////////////////////////////////
   // Host selects last one input clock rise per burst
   property p_rd_single;
      @(posedge k) disable iff (!reset_n) !rd_sel_n |=> rd_sel_n;
   endproperty
   a_rd_single: assert property (p_rd_single)
      else $error("read select held over two rises");

   property p_wr_single;
      @(posedge k) disable iff (!reset_n) !wr_sel_n |=> wr_sel_n;
   endproperty
   a_wr_single: assert property (p_wr_single)
      else $error("write select held over two rises");

endmodule // qrs_link_props

// >>> tb/testbench.sv
// Bench: host and device ends joined over the link, wide and narrow
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", nm, (exp), (got)); \
   end \
end

module testbench
   import qrs_pkg::*;
;
   localparam logic [DATA_W-1:0] NAR_MASK = 36'h00003ffff;
   localparam logic [BURST*DATA_W-1:0] DATA_A = {36'h9abcdef01,
      36'h876543210, 36'h13579bdf0, 36'h2468ace13};
   localparam logic [BURST*DATA_W-1:0] DATA_B = ~DATA_A;

   // Clock, reset, user side and bookkeeping
   logic                    sys_clk;
   logic                    reset_n;
   logic                    user_wr_req;
   logic                    user_rd_req;
   logic [ADDR_W-1:0]       user_addr;
   logic [BURST*DATA_W-1:0] user_wdata;
   logic [BURST*BW_N-1:0]   user_bw_n;
   logic                    user_dll_off_n;
   logic                    user_ready;
   logic [BURST*DATA_W-1:0] user_rdata;
   logic                    user_rvalid;
   logic                    busy_sys;
   logic [BURST*DATA_W-1:0] nar_rdata;
   int                      n_mismatch;
   int                      checks_done;
   logic [DATA_W-1:0]       model_mem [MEM_WORDS];

   ////////////////////////////////////////////////////////////////////////
   // Wide pair, a narrow pair fed the same requests, and the checker
   qrs_if lnk_if ();
   qrs_if nar_if ();
   qrs_sram_host qrs_sram_host_i (.lnk(lnk_if), .sys_clk, .reset_n,
      .user_wr_req, .user_rd_req, .user_addr, .user_wdata, .user_bw_n,
      .user_dll_off_n, .user_ready, .user_rdata, .user_rvalid);
   qrs_sram_dev #(.WIDE36(1'b1)) qrs_sram_dev_i (.lnk(lnk_if), .sys_clk,
      .reset_n, .busy_sys);
   qrs_sram_host qrs_sram_host_i2 (.lnk(nar_if), .sys_clk, .reset_n,
      .user_wr_req, .user_rd_req, .user_addr, .user_wdata, .user_bw_n,
      .user_dll_off_n, .user_ready(), .user_rdata(nar_rdata),
      .user_rvalid());
   qrs_sram_dev #(.WIDE36(1'b0)) qrs_sram_dev_i2 (.lnk(nar_if), .sys_clk,
      .reset_n, .busy_sys());
   qrs_link_props qrs_link_props_i (.sys_clk, .reset_n, .k(lnk_if.k),
      .k_n(lnk_if.k_n), .rd_sel_n(lnk_if.rd_sel_n),
      .wr_sel_n(lnk_if.wr_sel_n), .dll_off_n(lnk_if.dll_off_n),
      .read_data_out(lnk_if.read_data_out), .read_oe_n(lnk_if.read_oe_n),
      .echo_clk(lnk_if.echo_clk), .echo_clk_n(lnk_if.echo_clk_n),
      .output_valid_indicator(lnk_if.output_valid_indicator));

   ////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reset for 16 cycles, clear the model, check the idle state
   task automatic do_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (model_mem[i]) model_mem[i] = '0;
      @(posedge sys_clk);
      #1;
      `CHK("ready", 1'b1, user_ready)
      `CHK("read_oe_n", 1'b1, lnk_if.read_oe_n)
      `CHK("valid", 1'b0, lnk_if.output_valid_indicator)
      `CHK("busy", 1'b0, busy_sys)
   endtask

   // One burst through the host; reads are compared with the model
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [BURST*DATA_W-1:0] wd, input logic [BURST*BW_N-1:0] bw);
      int n;
      logic seen;
      logic [MEM_IDX_W+WSEL_W-1:0] ix;
      seen = 1'b0;
      @(posedge sys_clk);
      user_addr   <= a;
      user_wdata  <= wd;
      user_bw_n   <= bw;
      user_wr_req <= wr;
      user_rd_req <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (user_ready !== 1'b0 && n < 20);
      @(posedge sys_clk);
      user_wr_req <= 1'b0;
      user_rd_req <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
         if (busy_sys === 1'b1) seen = 1'b1;
      end while ((wr ? user_ready : user_rvalid) !== 1'b1 && n < 40);
      `CHK("done", 1'b1, (wr ? user_ready : user_rvalid))
      `CHK("busy_seen", 1'b1, seen)
      for (int w = 0; w < BURST; w++) begin
         ix = {a[MEM_IDX_W-1:0], w[WSEL_W-1:0]};
         for (int b = 0; b < BW_N; b++) begin
            if (wr && !bw[w*BW_N+b])
               model_mem[ix][b*BYTE_W+:BYTE_W] =
                  wd[w*DATA_W+b*BYTE_W+:BYTE_W];
         end
         if (!wr) begin
            `CHK("word", model_mem[ix], user_rdata[w*DATA_W+:DATA_W])
            `CHK("narrow", model_mem[ix] & NAR_MASK, nar_rdata[w*DATA_W+:DATA_W])
         end
      end
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      logic prev;
      reset_n = 1'b0;
      user_wr_req = 1'b0;
      user_rd_req = 1'b0;
      user_addr = '0;
      user_wdata = '0;
      user_bw_n = 16'hffff;
      user_dll_off_n = 1'b1;
      n_mismatch = 0;
      checks_done = 0;
      do_reset();
      // Echo clocks toggle while idle
      n = 0;
      prev = lnk_if.echo_clk;
      repeat (40) begin
         @(posedge sys_clk);
         #1;
         if (lnk_if.echo_clk !== prev) n++;
         prev = lnk_if.echo_clk;
      end
      `CHK("echo_toggles", 20, n)
      $display("test idle done");
      // Full, partial, untouched and top-of-range bursts
      xfer(1'b1, 18'h00003, DATA_A, 16'h0000);
      xfer(1'b0, 18'h00003, DATA_B, 16'hffff);
      xfer(1'b1, 18'h00005, DATA_B, 16'h0000);
      xfer(1'b1, 18'h00005, DATA_A, 16'h5a3c);
      xfer(1'b0, 18'h00005, DATA_B, 16'hffff);
      xfer(1'b0, 18'h00009, DATA_B, 16'hffff);
      xfer(1'b1, 18'h3fffa, DATA_B, 16'hf0f0);
      xfer(1'b0, 18'h3fffa, DATA_A, 16'hffff);
      $display("test bursts done");
      // Bypass mode, then back
      @(posedge sys_clk);
      user_dll_off_n <= 1'b0;
      repeat (40) @(posedge sys_clk);
      xfer(1'b0, 18'h00003, DATA_B, 16'hffff);
      xfer(1'b1, 18'h00003, DATA_B, 16'h0ff0);
      xfer(1'b0, 18'h00003, DATA_A, 16'hffff);
      user_dll_off_n <= 1'b1;
      repeat (40) @(posedge sys_clk);
      xfer(1'b0, 18'h00005, DATA_A, 16'hffff);
      $display("test bypass done");
      // Reset mid-run clears stored bursts
      do_reset();
      xfer(1'b0, 18'h00003, DATA_A, 16'hffff);
      $display("test rereset done");
      finish_test();
   end

endmodule // testbench
